// *** src/ssc_consts.vh ***
// ssc_consts.vh: offsets, field positions, reset values and timing counts
// for the self-programming section control block.
// assumes: included by bare name from every design file that needs it.
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// register byte offsets on the axi4-lite slave
`define SSC_OFS_CTRL_STATUS 8'h00
`define SSC_OFS_LOCK 8'h04
`define SSC_OFS_IRQ_STATUS 8'h08
`define SSC_OFS_IRQ_MASK 8'h0c
`define SSC_OFS_BOUNDS 8'h10

// program_store_ctrl_status fields
`define SSC_CS_BUSY_FLAG 0
`define SSC_CS_PROGRAMMING 1
`define SSC_CS_HALTED 2
`define SSC_CS_CLEAR_BUSY 4

// lock register fields: app lock in [1:0], boot lock in [3:2]
`define SSC_LOCK_APP_LO 0
`define SSC_LOCK_BOOT_LO 2
`define SSC_LOCK_UNPROG 2'h3

// interrupt status / mask bits
`define SSC_IRQ_DONE 0
`define SSC_IRQ_REFUSED 1
`define SSC_IRQ_RD_DENIED 2
`define SSC_IRQ_W 3

// axi response codes
`define SSC_RESP_OKAY 2'h0
`define SSC_RESP_SLVERR 2'h2

// page programming time and clock period
`define SSC_PROG_TIME_NS 4000000
`define SSC_CLK_PERIOD_NS 10
`define SSC_PROG_CYCLES (`SSC_PROG_TIME_NS / `SSC_CLK_PERIOD_NS)

// flash geometry defaults (word addresses)
`define SSC_ADDR_W 15
`define SSC_STALL_START 15'h7000
`define SSC_BOOT_MIN_WORDS 512

`endif

// *** src/ssc_lock_reg.v ***
// ssc_lock_reg.v: one section's pair of boot lock bits and their decode.
// assumes: chip_erase is a one-cycle pulse from the programming interface.
`timescale 1ns/10ps
`include "ssc_consts.vh"

module ssc_lock_reg (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // program requests (software or programming interface)
  input wire sw_we,
  input wire [1:0] sw_data,
  input wire pif_we,
  input wire [1:0] pif_data,
  input wire chip_erase,
  // state and decode
  output reg [1:0] lock_q,
  output wire write_ok,
  output wire xread_ok
);

  // bits may only go toward programmed (zero); only reset or chip erase restores ones
  always @(posedge core_clk) begin
    if (rst) begin
      lock_q <= `SSC_LOCK_UNPROG;
    end else if (chip_erase) begin
      lock_q <= `SSC_LOCK_UNPROG;
    end else begin
      lock_q <= lock_q & (sw_we ? sw_data : 2'h3) & (pif_we ? pif_data : 2'h3);
    end
  end

  // low bit programmed blocks store writes, high bit blocks cross reads
  assign write_ok = lock_q[0];
  assign xread_ok = lock_q[1];

endmodule // ssc_lock_reg

// *** src/ssc_prog_timer.v ***
// ssc_prog_timer.v: counts out one page erase or page write.
// assumes: start is a one-cycle pulse while the timer is idle.
`timescale 1ns/10ps

module ssc_prog_timer #(
  parameter integer CYCLES = 400000,
  parameter integer CNT_W = 20
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // control
  input wire start,
  output reg done_q
);

  reg [CNT_W-1:0] cnt_q;
  reg run_q;

  // done pulses CYCLES edges after start
  always @(posedge core_clk) begin
    if (rst) begin
      cnt_q <= {CNT_W{1'b0}};
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        cnt_q <= CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
        run_q <= 1'b1;
      end else if (run_q) begin
        if (cnt_q == {CNT_W{1'b0}}) begin
          run_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // ssc_prog_timer

// *** src/ssc_section_ctrl.v ***
// ssc_section_ctrl.v: self-programming section control, axi4-lite slave,
// store permission, stall / busy handling and lock bits.
// assumes: cpu inputs are synchronous to core_clk; addresses are word addresses.
`timescale 1ns/10ps
`include "ssc_consts.vh"

module ssc_section_ctrl #(
  parameter integer AW = `SSC_ADDR_W,
  parameter [AW-1:0] STALL_START = `SSC_STALL_START,
  parameter integer BOOT_MIN_WORDS = `SSC_BOOT_MIN_WORDS,
  parameter integer PROG_CYCLES = `SSC_PROG_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // axi4-lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // program_store_op from the cpu
  input wire op_req,
  input wire op_erase,
  input wire [AW-1:0] op_pc,
  input wire [AW-1:0] op_addr,
  // program_read_op check
  input wire rd_req,
  input wire [AW-1:0] rd_pc,
  input wire [AW-1:0] rd_addr,
  output reg rd_grant_q,
  output reg rd_deny_q,
  // fuses and programming interface
  input wire [1:0] boot_size_fuses,
  input wire pif_lock_we,
  input wire [3:0] pif_lock_data,
  input wire chip_erase,
  // flash array and cpu control
  output reg flash_erase_q,
  output reg flash_write_q,
  output reg [AW-1:0] flash_page_q,
  output reg cpu_halt_q,
  output reg region_busy_flag_q,
  output reg irq_q
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_PROG = 2'b10;
  localparam [AW:0] FLASH_END = {1'b1, {AW{1'b0}}};
  localparam [AW:0] BOOT_MIN = BOOT_MIN_WORDS[AW:0];

  // boot start from fuses: fuses 2'h3 give the smallest section
  function [AW-1:0] boot_start_f;
    input [1:0] fuses;
    reg [AW:0] start;
    begin
      start = FLASH_END - (BOOT_MIN << (2'h3 - fuses));
      if (start[AW-1:0] < STALL_START || start[AW]) begin
        boot_start_f = STALL_START;
      end else begin
        boot_start_f = start[AW-1:0];
      end
    end
  endfunction

  // section membership, used for pc and target alike
  function in_sect;
    input [AW-1:0] addr;
    input [AW-1:0] lower;
    begin
      in_sect = (addr >= lower);
    end
  endfunction

  reg [1:0] state_q;
  reg [AW-1:0] boot_start_q;
  reg [`SSC_IRQ_W-1:0] irq_stat_q;
  reg [`SSC_IRQ_W-1:0] irq_mask_q;
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire [1:0] app_lock;
  wire [1:0] boot_lock;
  wire app_wr_ok;
  wire app_xrd_ok;
  wire boot_wr_ok;
  wire boot_xrd_ok;
  wire prog_done;

  // one register write per handshake pair, only while no response pending
  wire do_wr = aw_full_q && w_full_q && !s_axi_bvalid;
  wire wr_byte0 = do_wr && wstrb_q[0];
  wire wr_ctrl = wr_byte0 && (awaddr_q == `SSC_OFS_CTRL_STATUS);
  wire wr_lock = wr_byte0 && (awaddr_q == `SSC_OFS_LOCK);
  wire wr_istat = wr_byte0 && (awaddr_q == `SSC_OFS_IRQ_STATUS);
  wire wr_imask = wr_byte0 && (awaddr_q == `SSC_OFS_IRQ_MASK);

  // store-op permission
  wire op_from_boot = in_sect(op_pc, boot_start_q);
  wire op_to_boot = in_sect(op_addr, boot_start_q);
  wire op_lock_ok = op_to_boot ? boot_wr_ok : app_wr_ok;
  wire op_accept = op_req && state_q[0] && op_from_boot && op_lock_ok;
  wire op_refuse = op_req && !op_accept;
  wire op_stall = in_sect(op_addr, STALL_START);

  // program_read_op permission
  wire rd_from_boot = in_sect(rd_pc, boot_start_q);
  wire rd_to_boot = in_sect(rd_addr, boot_start_q);
  wire rd_blocked = region_busy_flag_q && !in_sect(rd_addr, STALL_START);
  wire rd_xsect_bad = (rd_from_boot && !rd_to_boot && !app_xrd_ok) ||
                      (!rd_from_boot && rd_to_boot && !boot_xrd_ok);
  wire rd_bad = rd_req && (rd_blocked || rd_xsect_bad);

  wire [`SSC_IRQ_W-1:0] irq_ev = {rd_bad, op_refuse, prog_done};
  wire [`SSC_IRQ_W-1:0] irq_clr = wr_istat ? wdata_q[`SSC_IRQ_W-1:0] : {`SSC_IRQ_W{1'b0}};
  wire [`SSC_IRQ_W-1:0] irq_stat_d = (irq_stat_q & ~irq_clr) | irq_ev;

  // application and boot lock sets, each with its own decode
  ssc_lock_reg u_app_lock (
    .core_clk(core_clk),
    .rst(rst),
    .sw_we(wr_lock),
    .sw_data(wdata_q[`SSC_LOCK_APP_LO+1:`SSC_LOCK_APP_LO]),
    .pif_we(pif_lock_we),
    .pif_data(pif_lock_data[`SSC_LOCK_APP_LO+1:`SSC_LOCK_APP_LO]),
    .chip_erase(chip_erase),
    .lock_q(app_lock),
    .write_ok(app_wr_ok),
    .xread_ok(app_xrd_ok)
  );

  ssc_lock_reg u_boot_lock (
    .core_clk(core_clk),
    .rst(rst),
    .sw_we(wr_lock),
    .sw_data(wdata_q[`SSC_LOCK_BOOT_LO+1:`SSC_LOCK_BOOT_LO]),
    .pif_we(pif_lock_we),
    .pif_data(pif_lock_data[`SSC_LOCK_BOOT_LO+1:`SSC_LOCK_BOOT_LO]),
    .chip_erase(chip_erase),
    .lock_q(boot_lock),
    .write_ok(boot_wr_ok),
    .xread_ok(boot_xrd_ok)
  );

  // page erase / write duration
  ssc_prog_timer #(
    .CYCLES(PROG_CYCLES),
    .CNT_W(32)
  ) u_timer (
    .core_clk(core_clk),
    .rst(rst),
    .start(op_accept),
    .done_q(prog_done)
  );

  // boundary is re-read every cycle so fuse changes track without reset
  always @(posedge core_clk) begin
    if (rst) begin
      boot_start_q <= STALL_START;
    end else begin
      boot_start_q <= boot_start_f(boot_size_fuses);
    end
  end

  // programming sequencer
  always @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      flash_erase_q <= 1'b0;
      flash_write_q <= 1'b0;
      flash_page_q <= {AW{1'b0}};
      cpu_halt_q <= 1'b0;
      region_busy_flag_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (op_accept) begin
            state_q <= ST_PROG;
            flash_erase_q <= op_erase;
            flash_write_q <= !op_erase;
            flash_page_q <= op_addr;
            cpu_halt_q <= op_stall;
            if (!op_stall) begin
              region_busy_flag_q <= 1'b1;
            end
          end else if (wr_ctrl && wdata_q[`SSC_CS_CLEAR_BUSY]) begin
            region_busy_flag_q <= 1'b0;
          end
        end
        ST_PROG: begin
          // halt and busy hold for the entire page operation
          if (prog_done) begin
            state_q <= ST_IDLE;
            flash_erase_q <= 1'b0;
            flash_write_q <= 1'b0;
            cpu_halt_q <= 1'b0;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // read permission answers one cycle after the request
  always @(posedge core_clk) begin
    if (rst) begin
      rd_grant_q <= 1'b0;
      rd_deny_q <= 1'b0;
    end else begin
      rd_grant_q <= rd_req && !rd_bad;
      rd_deny_q <= rd_bad;
    end
  end

  // sticky events: a set in the clearing cycle survives
  always @(posedge core_clk) begin
    if (rst) begin
      irq_stat_q <= {`SSC_IRQ_W{1'b0}};
      irq_mask_q <= {`SSC_IRQ_W{1'b0}};
      irq_q <= 1'b0;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_imask) begin
        irq_mask_q <= wdata_q[`SSC_IRQ_W-1:0];
      end
      irq_q <= |(irq_stat_d & (wr_imask ? wdata_q[`SSC_IRQ_W-1:0] : irq_mask_q));
    end
  end

  // axi write path: address and data taken in either order
  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SSC_RESP_OKAY;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (awaddr_q)
          `SSC_OFS_CTRL_STATUS, `SSC_OFS_LOCK, `SSC_OFS_IRQ_STATUS,
          `SSC_OFS_IRQ_MASK, `SSC_OFS_BOUNDS: s_axi_bresp <= `SSC_RESP_OKAY;
          default: s_axi_bresp <= `SSC_RESP_SLVERR;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read path: data registered on the same edge that takes the address
  always @(posedge core_clk) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `SSC_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SSC_RESP_OKAY;
        s_axi_rdata <= 32'h0000_0000;
        case (s_axi_araddr)
          `SSC_OFS_CTRL_STATUS: begin
            s_axi_rdata[`SSC_CS_BUSY_FLAG] <= region_busy_flag_q;
            s_axi_rdata[`SSC_CS_PROGRAMMING] <= state_q[1];
            s_axi_rdata[`SSC_CS_HALTED] <= cpu_halt_q;
          end
          `SSC_OFS_LOCK: s_axi_rdata[3:0] <= {boot_lock, app_lock};
          `SSC_OFS_IRQ_STATUS: s_axi_rdata[`SSC_IRQ_W-1:0] <= irq_stat_q;
          `SSC_OFS_IRQ_MASK: s_axi_rdata[`SSC_IRQ_W-1:0] <= irq_mask_q;
          `SSC_OFS_BOUNDS: s_axi_rdata <= {{(16-AW){1'b0}}, STALL_START, {(16-AW){1'b0}}, boot_start_q};
          default: s_axi_rresp <= `SSC_RESP_SLVERR;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // ssc_section_ctrl

// *** bench/ssc_section_ctrl_monitor.sv ***
// ssc_section_ctrl_monitor.sv: assertions on the section control ports.
// assumes: bound into ssc_section_ctrl; all outputs are registered.
`timescale 1ns/10ps
module ssc_section_ctrl_monitor #(
  parameter integer AW = 15,
  parameter [AW-1:0] STALL_START = 15'h7000,
  parameter integer PROG_CYCLES = 20
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // cpu requests
  input wire op_req,
  input wire [AW-1:0] op_pc,
  input wire rd_req,
  input wire [AW-1:0] rd_pc,
  input wire [AW-1:0] rd_addr,
  input wire rd_grant_q,
  input wire rd_deny_q,
  // flash and cpu control
  input wire flash_erase_q,
  input wire flash_write_q,
  input wire [AW-1:0] flash_page_q,
  input wire cpu_halt_q,
  input wire region_busy_flag_q
);
  // smallest boot section is the top 512 words, so this lies in it for every fuse value
  localparam [AW-1:0] TOP_BOOT = 15'h7e00;
  wire act = flash_erase_q | flash_write_q;
  reg [31:0] cnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // length of the running page operation
  always @(posedge core_clk) begin
    if (rst || !act) cnt_q <= 32'h0;
    else cnt_q <= cnt_q + 32'h1;
  end
  property p_app_ignored; op_req && !act && op_pc < STALL_START |=> !act; endproperty
  a_app_ignored: assert property (p_app_ignored) else $error("store from application started");
  property p_halt; $rose(act) && flash_page_q >= STALL_START |-> cpu_halt_q; endproperty
  a_halt: assert property (p_halt) else $error("stalling page op without halt");
  property p_run; act && flash_page_q < STALL_START |-> !cpu_halt_q && region_busy_flag_q; endproperty
  a_run: assert property (p_run) else $error("concurrent page op halted or not busy");
  property p_halt_only; cpu_halt_q |-> act; endproperty
  a_halt_only: assert property (p_halt_only) else $error("halt outside page op");
  // the page op is live from the take edge until the edge after the timer's done pulse
  property p_len; !$past(rst) && $fell(act) |-> cnt_q == PROG_CYCLES + 1; endproperty
  a_len: assert property (p_len) else $error("page op length wrong");
  property p_deny; rd_req && region_busy_flag_q && rd_addr < STALL_START |=> rd_deny_q && !rd_grant_q; endproperty
  a_deny: assert property (p_deny) else $error("blocked region read not denied");
  property p_grant; rd_req && rd_pc >= TOP_BOOT && rd_addr >= TOP_BOOT |=> rd_grant_q ##1 !rd_grant_q; endproperty
  a_grant: assert property (p_grant) else $error("stalling region read not granted");
  property p_busy_kept;
    !$past(rst) && $fell(act) && $past(flash_page_q) < STALL_START |-> region_busy_flag_q;
  endproperty
  a_busy_kept: assert property (p_busy_kept) else $error("busy flag dropped at completion");
  c_halt: cover property ($rose(cpu_halt_q));
  c_busy: cover property ($rose(region_busy_flag_q));
  c_deny: cover property (rd_deny_q);
endmodule // ssc_section_ctrl_monitor

bind ssc_section_ctrl ssc_section_ctrl_monitor #(
  .AW(AW), .STALL_START(STALL_START), .PROG_CYCLES(PROG_CYCLES)
) i_mon (
  .core_clk(core_clk), .rst(rst), .op_req(op_req), .op_pc(op_pc), .rd_req(rd_req), .rd_pc(rd_pc),
  .rd_addr(rd_addr), .rd_grant_q(rd_grant_q), .rd_deny_q(rd_deny_q), .flash_erase_q(flash_erase_q),
  .flash_write_q(flash_write_q), .flash_page_q(flash_page_q), .cpu_halt_q(cpu_halt_q),
  .region_busy_flag_q(region_busy_flag_q)
);

// *** bench/ssc_cpu_model.sv ***
// ssc_cpu_model.sv: cpu core issuing store and program-read requests.
// assumes: tasks are called by the bench; each request is a one-cycle pulse.
`timescale 1ns/10ps
module ssc_cpu_model (
  // clock and status
  input wire core_clk,
  input wire cpu_halt_q,
  input wire region_busy_flag_q,
  // requests
  output reg op_req,
  output reg op_erase,
  output reg [14:0] op_pc,
  output reg [14:0] op_addr,
  output reg rd_req,
  output reg [14:0] rd_pc,
  output reg [14:0] rd_addr
);
  // quiet values at time zero
  initial begin
    op_req = 1'b0;
    op_erase = 1'b0;
    op_pc = 15'h0;
    op_addr = 15'h0;
    rd_req = 1'b0;
    rd_pc = 15'h0;
    rd_addr = 15'h0;
  end
  // one store op; a stalled core issues nothing; stale fields are inverted after use
  task store(input e, input [14:0] pc, input [14:0] a);
    begin
      @(posedge core_clk);
      while (cpu_halt_q) @(posedge core_clk);
      op_req <= 1'b1;
      op_erase <= e;
      op_pc <= pc;
      op_addr <= a;
      @(posedge core_clk);
      op_req <= 1'b0;
      op_erase <= ~e;
      op_pc <= ~pc;
      op_addr <= ~a;
    end
  endtask
  // one program read; vectors sit in the boot section, so only bad reaches the busy region
  task fetch(input [14:0] pc, input [14:0] a, input bad);
    begin
      @(posedge core_clk);
      while (region_busy_flag_q && a < 15'h7000 && !bad) @(posedge core_clk);
      rd_req <= 1'b1;
      rd_pc <= pc;
      rd_addr <= a;
      @(posedge core_clk);
      rd_req <= 1'b0;
      rd_pc <= ~pc;
      rd_addr <= ~a;
    end
  endtask
endmodule // ssc_cpu_model

// *** bench/selfprog_section_control_tb.sv ***
// selfprog_section_control_tb.sv: self-checking bench for the section control block.
// assumes: cpu model drives the store and read ports; page op shortened to 20 cycles.
`timescale 1ns/10ps
module selfprog_section_control_tb;
  localparam integer PC = 20;
  reg core_clk, rst, awvalid, wvalid, bready, arvalid, rready, pif_lock_we, chip_erase;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, rdat, rnd;
  reg [3:0] pif_lock_data;
  reg [1:0] boot_size_fuses, brsp, rrsp;
  wire awready, wready, bvalid, arready, rvalid, op_req, op_erase, rd_req, rd_grant_q, rd_deny_q;
  wire flash_erase_q, flash_write_q, cpu_halt_q, region_busy_flag_q, irq_q;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [14:0] op_pc, op_addr, rd_pc, rd_addr, flash_page_q;
  integer compares, miscompares, lock_m, busy_m, i;
  ssc_section_ctrl #(.PROG_CYCLES(PC)) i_dut (
    .core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .op_req(op_req), .op_erase(op_erase), .op_pc(op_pc), .op_addr(op_addr),
    .rd_req(rd_req), .rd_pc(rd_pc), .rd_addr(rd_addr), .rd_grant_q(rd_grant_q), .rd_deny_q(rd_deny_q),
    .boot_size_fuses(boot_size_fuses), .pif_lock_we(pif_lock_we), .pif_lock_data(pif_lock_data),
    .chip_erase(chip_erase), .flash_erase_q(flash_erase_q), .flash_write_q(flash_write_q),
    .flash_page_q(flash_page_q), .cpu_halt_q(cpu_halt_q), .region_busy_flag_q(region_busy_flag_q), .irq_q(irq_q)
  );
  ssc_cpu_model i_cpu (
    .core_clk(core_clk), .cpu_halt_q(cpu_halt_q), .region_busy_flag_q(region_busy_flag_q), .op_req(op_req),
    .op_erase(op_erase), .op_pc(op_pc), .op_addr(op_addr), .rd_req(rd_req), .rd_pc(rd_pc), .rd_addr(rd_addr)
  );
  // clock and watchdog
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares = miscompares + 1;
    report_and_stop;
  end
  function [31:0] lfsr(input [31:0] v);
    lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // boot section start in words for a fuse setting, never below the stalling region
  function integer bs(input [1:0] f);
    begin
      bs = 32768 - (512 << (3 - f));
      if (bs < 28672) bs = 28672;
    end
  endfunction
  // expected read grant from busy state and the cross-section locks
  function integer gr(input integer pc, input integer a);
    integer b;
    begin
      b = bs(boot_size_fuses);
      gr = !(busy_m && a < 28672) && !(pc >= b && a < b && !lock_m[1]) && !(pc < b && a >= b && !lock_m[3]);
    end
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // pending flags are kept locally: valid itself still reads its old value in the edge that raised it
  task wr(input [7:0] a, input [31:0] d);
    integer pa, pw;
    begin
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      pa = 1;
      pw = 1;
      while (pa || pw) begin
        @(posedge core_clk);
        if (pa && awready) begin
          awvalid <= 1'b0;
          pa = 0;
        end
        if (pw && wready) begin
          wvalid <= 1'b0;
          pw = 0;
        end
      end
      while (!bvalid) @(posedge core_clk);
      brsp = bresp;
      bready <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge core_clk); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge core_clk);
      rdat = rdata;
      rrsp = rresp;
      rready <= 1'b0;
    end
  endtask
  task chk_reg(input [7:0] a, input [31:0] exp);
    begin
      rd(a);
      chk(rdat, exp);
      chk(rrsp, 2'h0);
    end
  endtask
  // one store op through the cpu, then its whole run compared with the model
  task op(input e, input [14:0] pc, input [14:0] a);
    integer ok, n;
    begin
      ok = pc >= bs(boot_size_fuses) && ((a >= bs(boot_size_fuses)) ? lock_m[2] : lock_m[0]);
      i_cpu.store(e, pc, a);
      #1;
      chk(flash_erase_q, ok && e);
      chk(flash_write_q, ok && !e);
      if (ok) chk(flash_page_q, a);
      chk(cpu_halt_q, ok && a >= 28672);
      if (ok && a < 28672) busy_m = 1;
      chk(region_busy_flag_q, busy_m);
      n = 0;
      while (ok && (flash_erase_q || flash_write_q) && n < 99) begin
        @(posedge core_clk);
        #1;
        n = n + 1;
      end
      if (ok) chk(n, PC + 1);
      chk(region_busy_flag_q, busy_m);
    end
  endtask
  task fetch(input [14:0] pc, input [14:0] a, input bad);
    integer g;
    begin
      g = gr(pc, a);
      i_cpu.fetch(pc, a, bad);
      #1;
      chk(rd_grant_q, g);
      chk(rd_deny_q, !g);
    end
  endtask
  task report_and_stop;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  // main sequence
  initial begin
    compares = 0;
    miscompares = 0;
    lock_m = 15;
    busy_m = 0;
    rnd = 32'h8bc1;
    {rst, awvalid, wvalid, bready, arvalid, rready, pif_lock_we, chip_erase} = 8'h80;
    {awaddr, araddr, wdata, pif_lock_data, boot_size_fuses} = 54'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    chk_reg(8'h00, 32'h0);
    chk_reg(8'h04, 32'hf);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge core_clk);
      boot_size_fuses <= i;
      @(posedge core_clk);
      chk_reg(8'h10, (28672 << 16) | bs(i));
    end
    rd(8'h14);
    chk(rrsp, 2'h2);
    wr(8'h14, 32'hf);
    chk(brsp, 2'h2);
    $display("test reset and bounds done");
    // refused op from the application section raises the refused interrupt
    wr(8'h0c, 32'h7);
    op(1'b0, 15'h0100, 15'h0200);
    chk(irq_q, 1'b1);
    chk_reg(8'h08, 32'h2);
    wr(8'h08, 32'h7);
    chk(irq_q, 1'b0);
    // concurrent region op with reads running alongside
    rnd = lfsr(rnd);
    fork
      op(1'b0, 15'h7f00, {1'b0, rnd[13:8] % 6'h38, 8'h00});
      begin
        repeat (3) @(posedge core_clk);
        fetch(15'h7f00, 15'h7f10, 1'b0);
        fetch(15'h7f00, 15'h0040, 1'b1);
      end
    join
    chk(irq_q, 1'b1);
    chk_reg(8'h00, 32'h1);
    wr(8'h00, 32'h10);
    busy_m = 0;
    chk_reg(8'h00, 32'h0);
    wr(8'h08, 32'h7);
    $display("test concurrent op done");
    op(1'b1, 15'h7f00, 15'h7f80);
    op(1'b0, 15'h7f00, 15'h7040);
    $display("test stalling op done");
    // lock patterns, then chip erase and the programming interface
    wr(8'h04, 32'he);
    lock_m = lock_m & 14;
    chk_reg(8'h04, lock_m);
    op(1'b0, 15'h7f00, 15'h0100);
    op(1'b0, 15'h7f00, 15'h7f00);
    wr(8'h04, 32'h3);
    lock_m = lock_m & 3;
    chk_reg(8'h04, lock_m);
    op(1'b1, 15'h7f00, 15'h7f00);
    fetch(15'h0100, 15'h7f00, 1'b0);
    fetch(15'h7f00, 15'h0100, 1'b0);
    @(posedge core_clk);
    chip_erase <= 1'b1;
    @(posedge core_clk);
    chip_erase <= 1'b0;
    pif_lock_data <= 4'h5;
    lock_m = 15;
    chk_reg(8'h04, 32'hf);
    @(posedge core_clk);
    pif_lock_we <= 1'b1;
    @(posedge core_clk);
    pif_lock_we <= 1'b0;
    lock_m = 5;
    chk_reg(8'h04, 32'h5);
    $display("test locks done");
    // random pages and code locations with interrupts masked
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'h7);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = lfsr(rnd);
      op(rnd[0], rnd[1] ? 15'h7f00 : 15'h0100, {rnd[14:8], 8'h00});
      chk(irq_q, 1'b0);
      if (busy_m) wr(8'h00, 32'h10);
      busy_m = 0;
    end
    $display("test random ops done");
    report_and_stop;
  end
endmodule // selfprog_section_control_tb
